// *** logic/buck_regs_pkg.sv ***
// Overview of operation
// R1: Four 8-bit scratch bytes survive main supply loss
// R2: Scratch bytes cleared only by coin-cell reset
// R3: Buck A normal code bits 4:0 drives regulator
// R4: Buck A standby code bits 4:0 in standby
// R5: Buck A sleep code bits 4:0 in sleep
// R6: Mode bit 5 picks off or sleep
// R7: Mode bits 3:0 select switching mode
// R8: Config bit 6 sets ramp step period
// R9: Config bits 5:4 select phase clock
// R10: Config bits 3:2 select switching frequency
// R11: Config bit 0 selects current limit
// R12: Buck B has normal, standby, sleep codes
// R13: Host accesses registers in any state
// R14: Buck defaults load from OTP at reset
// R15: Unassigned bits read zero, ignore writes
package buck_regs_pkg;
	// ==========================================
	// Register byte addresses
	localparam logic [7:0] ADDR_SCRATCH_A = 8'h00;
	localparam logic [7:0] ADDR_SCRATCH_B = 8'h04;
	localparam logic [7:0] ADDR_SCRATCH_C = 8'h08;
	localparam logic [7:0] ADDR_SCRATCH_D = 8'h0C;
	localparam logic [7:0] ADDR_A_NORMAL = 8'h10;
	localparam logic [7:0] ADDR_A_STANDBY = 8'h14;
	localparam logic [7:0] ADDR_A_SLEEP = 8'h18;
	localparam logic [7:0] ADDR_A_MODE = 8'h1C;
	localparam logic [7:0] ADDR_A_CONF = 8'h20;
	localparam logic [7:0] ADDR_B_NORMAL = 8'h24;
	localparam logic [7:0] ADDR_B_STANDBY = 8'h28;
	localparam logic [7:0] ADDR_B_SLEEP = 8'h2C;
	// ==========================================
	// Field masks of implemented bits
	localparam logic [7:0] MASK_SCRATCH = 8'hFF;
	localparam logic [7:0] MASK_VOLT = 8'h1F;
	localparam logic [7:0] MASK_MODE = 8'h2F;
	localparam logic [7:0] MASK_CONF = 8'h7D;
	// ==========================================
	// Field positions
	localparam int MODE_OFF_BIT = 5;
	localparam int CONF_RAMP_BIT = 6;
	localparam int CONF_PHASE_LSB = 4;
	localparam int CONF_FREQ_LSB = 2;
	localparam int CONF_ILIM_BIT = 0;
	localparam logic [7:0] SCRATCH_RESET = 8'h00;
	// ==========================================
	// Ramp step periods
	localparam int CLK_HZ = 40000000;
	localparam int RAMP_FAST_NS = 2000;
	localparam int RAMP_SLOW_NS = 4000;
	localparam int RAMP_FAST_CYC = (RAMP_FAST_NS * (CLK_HZ / 1000000)) / 1000;
	localparam int RAMP_SLOW_CYC = (RAMP_SLOW_NS * (CLK_HZ / 1000000)) / 1000;
	// ==========================================
	// Operating state of a channel
	typedef enum logic [2:0] {
		OP_NORMAL = 3'b001,
		OP_STANDBY = 3'b010,
		OP_SLEEP = 3'b100
	} op_state_t;
	// Settings bundle of one channel for the regulator
	typedef struct packed {
		logic [4:0] volt_code;
		logic [3:0] switch_mode;
		logic turnoff_sel;
		logic ramp_rate;
		logic [1:0] phase_sel;
		logic [1:0] freq_sel;
		logic ilim_sel;
	} buck_ctrl_t;
	// OTP default image of the buck registers
	typedef struct packed {
		logic [7:0] a_normal;
		logic [7:0] a_standby;
		logic [7:0] a_sleep;
		logic [7:0] a_mode;
		logic [7:0] a_conf;
		logic [7:0] b_normal;
		logic [7:0] b_standby;
		logic [7:0] b_sleep;
	} otp_image_t;
endpackage : buck_regs_pkg

// *** logic/buck_config_and_backup_mem_regs.sv ***
// Implementation choices: the APB register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module buck_config_and_backup_mem_regs #(
	// Ramp step periods in clock cycles
	parameter int RAMP_FAST_CYC = buck_regs_pkg::RAMP_FAST_CYC,
	parameter int RAMP_SLOW_CYC = buck_regs_pkg::RAMP_SLOW_CYC,
	// Width of the ramp step counter
	parameter int RAMP_CNT_W = 13
) (
	// Clock and resets
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic coin_cell_por_n,
	// OTP defaults, sampled after main reset release
	input wire buck_regs_pkg::otp_image_t otp_image,
	// Operating state requests
	input wire logic standby_req,
	input wire logic turnoff_req,
	// APB slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Regulator controls
	output buck_regs_pkg::buck_ctrl_t buck_a_ctrl,
	output logic [4:0] buck_b_volt_code,
	output logic buck_a_off,
	output logic buck_a_step_en,
	output logic buck_b_step_en,
	output logic otp_loaded
);
	// ==========================================
	// Register storage
	logic [7:0] scratch_reg [4];
	logic [7:0] buck_reg [8];
	logic load_pending_reg;
	logic [RAMP_CNT_W-1:0] ramp_cnt_reg;
	logic [RAMP_CNT_W-1:0] ramp_cnt_next;
	buck_regs_pkg::op_state_t op_reg;
	buck_regs_pkg::op_state_t op_next;

	// ==========================================
	// Slots of the buck register array
	localparam int IDX_A_NORMAL = 0;
	localparam int IDX_A_STANDBY = 1;
	localparam int IDX_A_SLEEP = 2;
	localparam int IDX_A_MODE = 3;
	localparam int IDX_A_CONF = 4;
	localparam int IDX_B_NORMAL = 5;
	localparam int IDX_B_STANDBY = 6;
	localparam int IDX_B_SLEEP = 7;

	// ==========================================
	// Elaboration checks
	// Below two cycles the step pulse would never fall
	if (RAMP_FAST_CYC < 2 || RAMP_SLOW_CYC < 2) begin : g_bad_period
		$error("Ramp step period below two cycles");
	end
	// Limits below are worked out in 32-bit integers
	if (RAMP_CNT_W < 1 || RAMP_CNT_W > 30) begin : g_bad_cnt_w
		$error("Ramp counter width out of range");
	end
	// The counter must reach the longer of the two periods
	if (RAMP_SLOW_CYC > (1 << RAMP_CNT_W) ||
		RAMP_FAST_CYC > (1 << RAMP_CNT_W)) begin : g_bad_width
		$error("Ramp step counter too narrow");
	end
	// The OTP image is unpacked as eight bytes
	if ($bits(buck_regs_pkg::otp_image_t) != 64) begin : g_bad_otp
		$error("OTP image is not eight bytes");
	end
	// Masks must keep the ramp and turn-off bits that the logic reads
	localparam logic RAMP_KEPT =
		buck_regs_pkg::MASK_CONF[buck_regs_pkg::CONF_RAMP_BIT];
	localparam logic OFF_KEPT =
		buck_regs_pkg::MASK_MODE[buck_regs_pkg::MODE_OFF_BIT];
	if (!RAMP_KEPT || !OFF_KEPT) begin : g_bad_mask
		$error("Field mask drops a used bit");
	end

	function automatic logic [3:0] scratch_idx(input logic [7:0] a);
		unique case (a)
			buck_regs_pkg::ADDR_SCRATCH_A: scratch_idx = 4'h1;
			buck_regs_pkg::ADDR_SCRATCH_B: scratch_idx = 4'h2;
			buck_regs_pkg::ADDR_SCRATCH_C: scratch_idx = 4'h4;
			buck_regs_pkg::ADDR_SCRATCH_D: scratch_idx = 4'h8;
			default: scratch_idx = 4'h0;
		endcase
	endfunction : scratch_idx

	function automatic logic [7:0] buck_idx(input logic [7:0] a);
		unique case (a)
			buck_regs_pkg::ADDR_A_NORMAL: buck_idx = 8'h01;
			buck_regs_pkg::ADDR_A_STANDBY: buck_idx = 8'h02;
			buck_regs_pkg::ADDR_A_SLEEP: buck_idx = 8'h04;
			buck_regs_pkg::ADDR_A_MODE: buck_idx = 8'h08;
			buck_regs_pkg::ADDR_A_CONF: buck_idx = 8'h10;
			buck_regs_pkg::ADDR_B_NORMAL: buck_idx = 8'h20;
			buck_regs_pkg::ADDR_B_STANDBY: buck_idx = 8'h40;
			buck_regs_pkg::ADDR_B_SLEEP: buck_idx = 8'h80;
			default: buck_idx = 8'h00;
		endcase
	endfunction : buck_idx

	function automatic logic [7:0] buck_mask(input int i);
		if (i == 3)
			buck_mask = buck_regs_pkg::MASK_MODE;
		else if (i == 4)
			buck_mask = buck_regs_pkg::MASK_CONF;
		else
			buck_mask = buck_regs_pkg::MASK_VOLT;
	endfunction : buck_mask

	// ==========================================
	// Bus decode
	wire logic access_en = psel && penable;
	wire logic write_en = access_en && pwrite && pstrb[0];
	wire logic [3:0] scratch_hit = scratch_idx(paddr);
	wire logic [7:0] buck_hit = buck_idx(paddr);
	wire logic mapped = (scratch_hit != 4'h0) || (buck_hit != 8'h00);
	wire logic [63:0] otp_flat = otp_image;
	logic [7:0] rd_byte;
	wire logic setup_phase = psel && !penable;
	wire logic [3:0] scratch_wr = {4{write_en}} & scratch_hit;
	wire logic [7:0] buck_wr = {8{write_en}} & buck_hit;

	// ==========================================
	// Named fields of the buck register bytes
	wire logic [7:0] a_mode_byte = buck_reg[IDX_A_MODE];
	wire logic [7:0] a_conf_byte = buck_reg[IDX_A_CONF];
	wire logic off_to_sleep = a_mode_byte[buck_regs_pkg::MODE_OFF_BIT];
	wire logic ramp_slow = a_conf_byte[buck_regs_pkg::CONF_RAMP_BIT];

	// Voltage codes of each operating state
	wire logic [4:0] a_normal_code = buck_reg[IDX_A_NORMAL][4:0];
	wire logic [4:0] a_standby_code = buck_reg[IDX_A_STANDBY][4:0];
	wire logic [4:0] a_sleep_code = buck_reg[IDX_A_SLEEP][4:0];
	wire logic [4:0] b_normal_code = buck_reg[IDX_B_NORMAL][4:0];
	wire logic [4:0] b_standby_code = buck_reg[IDX_B_STANDBY][4:0];
	wire logic [4:0] b_sleep_code = buck_reg[IDX_B_SLEEP][4:0];

	// Hits are one-hot, so the order of the loops does not matter
	always_comb begin
		rd_byte = 8'h00;
		for (int i = 0; i < 4; i++) begin
			if (scratch_hit[i])
				rd_byte = scratch_reg[i];
		end
		for (int i = 0; i < 8; i++) begin
			if (buck_hit[i])
				rd_byte = buck_reg[i]; // R15
		end
	end

	// ==========================================
	// Scratch bytes on the coin-cell domain
	// Main reset must not touch these, else data is lost on every brownout
	genvar g;
	generate
		for (g = 0; g < 4; g++) begin : g_scratch
			always_ff @(posedge sys_clk or negedge coin_cell_por_n) begin
				if (!coin_cell_por_n)
					scratch_reg[g] <= buck_regs_pkg::SCRATCH_RESET; // R2
				else if (scratch_wr[g])
					scratch_reg[g] <= pwdata[7:0]; // R1
			end
		end
	endgenerate

	// ==========================================
	// Buck registers, OTP load one cycle after release
	generate
		for (g = 0; g < 8; g++) begin : g_buck
			always_ff @(posedge sys_clk or negedge rst_b) begin
				if (!rst_b)
					buck_reg[g] <= 8'h00;
				else if (load_pending_reg)
					buck_reg[g] <= otp_flat[(7-g)*8 +: 8] & buck_mask(g); // R14
				else if (buck_wr[g])
					buck_reg[g] <= pwdata[7:0] & buck_mask(g); // R13 R15
			end
		end
	endgenerate

	// Loading one edge after release keeps OTP sampling off the reset edge
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			load_pending_reg <= 1'b1;
		else
			load_pending_reg <= 1'b0;
	end

	// ==========================================
	// APB answer, zero wait states
	// Ready is raised for the access phase that follows every setup cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			pready <= 1'b0;
		else
			pready <= setup_phase; // R13
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			pslverr <= 1'b0;
		else
			pslverr <= setup_phase && !mapped;
	end

	// Read data is taken in setup so it stands through the access phase
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			prdata <= 32'h0000_0000;
		else
			prdata <= {24'h00_0000, rd_byte}; // R15
	end

	// ==========================================
	// Operating state: turn-off with the sleep choice wins over standby
	// Turn-off with the sleep choice moves both channels to sleep codes
	always_comb begin
		if (turnoff_req && off_to_sleep)
			op_next = buck_regs_pkg::OP_SLEEP; // R6
		else if (standby_req)
			op_next = buck_regs_pkg::OP_STANDBY;
		else
			op_next = buck_regs_pkg::OP_NORMAL;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			op_reg <= buck_regs_pkg::OP_NORMAL;
		else
			op_reg <= op_next;
	end

	// ==========================================
	// Ramp step enable, shared by both channels
	// Channel B has no config here, so it follows channel A rate
	wire logic [RAMP_CNT_W-1:0] ramp_period = ramp_slow ?
		RAMP_CNT_W'(RAMP_SLOW_CYC) :
		RAMP_CNT_W'(RAMP_FAST_CYC); // R8
	wire logic ramp_tick = (ramp_cnt_reg >= ramp_period - RAMP_CNT_W'(1));
	assign ramp_cnt_next = ramp_tick ? '0 : ramp_cnt_reg + RAMP_CNT_W'(1);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			ramp_cnt_reg <= '0;
		else
			ramp_cnt_reg <= ramp_cnt_next;
	end

	// ==========================================
	// Regulator outputs, registered
	logic [4:0] a_code;
	logic [4:0] b_code;

	always_comb begin
		unique case (op_reg)
			buck_regs_pkg::OP_NORMAL: begin
				a_code = a_normal_code; // R3
				b_code = b_normal_code; // R12
			end
			buck_regs_pkg::OP_STANDBY: begin
				a_code = a_standby_code; // R4
				b_code = b_standby_code; // R12
			end
			buck_regs_pkg::OP_SLEEP: begin
				a_code = a_sleep_code; // R5
				b_code = b_sleep_code; // R12
			end
			// Illegal state codes fall back to the normal codes
			default: begin
				a_code = a_normal_code;
				b_code = b_normal_code;
			end
		endcase
	end

	// Control word of channel A, gathered ahead of its flip-flop
	wire buck_regs_pkg::buck_ctrl_t a_ctrl_next = '{
		volt_code: a_code,
		switch_mode: a_mode_byte[3:0], // R7
		turnoff_sel: off_to_sleep,
		ramp_rate: ramp_slow,
		phase_sel: a_conf_byte[buck_regs_pkg::CONF_PHASE_LSB +: 2], // R9
		freq_sel: a_conf_byte[buck_regs_pkg::CONF_FREQ_LSB +: 2], // R10
		ilim_sel: a_conf_byte[buck_regs_pkg::CONF_ILIM_BIT] // R11
	};

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			buck_a_ctrl <= '0;
		else
			buck_a_ctrl <= a_ctrl_next;
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			buck_b_volt_code <= 5'h00;
		else
			buck_b_volt_code <= b_code; // R12
	end

	// Off only when the mode bit asks for full turn-off, not sleep
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			buck_a_off <= 1'b0;
		else
			buck_a_off <= turnoff_req && !off_to_sleep; // R6
	end

	// Both channels step together, one pulse per ramp period
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			buck_a_step_en <= 1'b0;
		else
			buck_a_step_en <= ramp_tick; // R8
	end

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			buck_b_step_en <= 1'b0;
		else
			buck_b_step_en <= ramp_tick; // R8
	end

	// Tells the host that the OTP defaults are in place
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b)
			otp_loaded <= 1'b0;
		else
			otp_loaded <= !load_pending_reg; // R14
	end
endmodule : buck_config_and_backup_mem_regs
`default_nettype wire

// *** sim/buck_regs_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Port checker
module buck_regs_checker (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_b,
	// Stimulus side
	input wire buck_regs_pkg::otp_image_t otp_image,
	input wire logic standby_req,
	input wire logic turnoff_req,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	// Design outputs
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	input wire buck_regs_pkg::buck_ctrl_t buck_a_ctrl,
	input wire logic [4:0] buck_b_volt_code,
	input wire logic buck_a_off,
	input wire logic buck_a_step_en,
	input wire logic otp_loaded
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	sequence s_wr_norm;
		psel && penable && pwrite && pstrb[0]
			&& paddr == buck_regs_pkg::ADDR_A_NORMAL;
	endsequence
	sequence s_quiet;
		(!standby_req && !turnoff_req)[*2];
	endsequence
	property p_rdy; psel && !penable |=> pready; endproperty
	a_rdy: assert property (p_rdy) else $error("pready missing");
	property p_one; pready |=> !pready; endproperty
	a_one: assert property (p_one) else $error("pready held");
	property p_err;
		psel && !penable && !pwrite && paddr > 8'h2C
			|=> pslverr && prdata == 32'h0;
	endproperty
	a_err: assert property (p_err) else $error("unmapped read");
	property p_hi; pready |-> prdata[31:8] == 24'h0; endproperty
	a_hi: assert property (p_hi) else $error("prdata high bits");
	property p_norm;
		s_wr_norm ##1 s_quiet |-> buck_a_ctrl.volt_code == $past(pwdata[4:0], 2);
	endproperty
	a_norm: assert property (p_norm) else $error("normal code");
	property p_off;
		(turnoff_req && !buck_a_ctrl.turnoff_sel)[*2] |=> buck_a_off;
	endproperty
	a_off: assert property (p_off) else $error("no turn off");
	property p_on; !turnoff_req |=> !buck_a_off; endproperty
	a_on: assert property (p_on) else $error("stray turn off");
	// Rate change alters the period mid-count, so accept it as an exit
	property p_fast;
		buck_a_step_en && !buck_a_ctrl.ramp_rate
			|-> ##80 (buck_a_step_en || buck_a_ctrl.ramp_rate);
	endproperty
	a_fast: assert property (p_fast) else $error("fast step");
	property p_slow;
		buck_a_step_en && buck_a_ctrl.ramp_rate
			|-> ##160 (buck_a_step_en || !buck_a_ctrl.ramp_rate);
	endproperty
	a_slow: assert property (p_slow) else $error("slow step");
	property p_otp;
		$rose(otp_loaded) && !standby_req && !turnoff_req
			|-> buck_b_volt_code == otp_image.b_normal[4:0];
	endproperty
	a_otp: assert property (p_otp) else $error("otp default");
endmodule : buck_regs_checker
bind buck_config_and_backup_mem_regs buck_regs_checker chk_i (.sys_clk,
	.rst_b, .otp_image, .standby_req, .turnoff_req, .psel, .penable, .pwrite,
	.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .buck_a_ctrl,
	.buck_b_volt_code, .buck_a_off, .buck_a_step_en, .otp_loaded);
`default_nettype wire

// *** sim/apb_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ========================================
// Host processor on the register port
module apb_host_model (
	// Clock
	input wire logic sys_clk,
	// APB
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata,
	output logic [3:0] pstrb,
	input wire logic [31:0] prdata,
	input wire logic pready
);
	initial begin
		psel = 1'h0;
		penable = 1'h0;
		pwrite = 1'h0;
		paddr = 8'h00;
		pwdata = 32'h0;
		pstrb = 4'h0;
	end
	// Any register, any time; no fixed answer latency assumed
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, input logic [3:0] s, output logic [31:0] q);
		@(posedge sys_clk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge sys_clk);
		penable <= 1'h1;
		do @(posedge sys_clk); while (pready !== 1'h1);
		q = prdata;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask : xfer
endmodule : apb_host_model
`default_nettype wire

// *** sim/testbench.sv ***
`timescale 1ns/100ps
`default_nettype none
module testbench;
	logic sys_clk = 1'h0;
	logic rst_b = 1'h0;
	logic coin_cell_por_n = 1'h0;
	logic standby_req = 1'h0;
	logic turnoff_req = 1'h0;
	buck_regs_pkg::otp_image_t otp_image = 64'hF3EAC5FFFF31264C;
	logic psel, penable, pwrite, pready, pslverr;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata;
	logic [3:0] pstrb;
	buck_regs_pkg::buck_ctrl_t buck_a_ctrl;
	logic [4:0] buck_b_volt_code;
	logic buck_a_off, buck_a_step_en, buck_b_step_en, otp_loaded;
	logic [7:0] cfg [4:11] = '{8'h03, 8'h07, 8'h09, 8'h25, 8'h35, 8'h0B,
		8'h0D, 8'h0E};
	int miscompares = 0;
	int checked = 0;
	int cyc = 0;
	int n;
	always #12.5 sys_clk = ~sys_clk;
	buck_config_and_backup_mem_regs dut (.sys_clk, .rst_b, .coin_cell_por_n,
		.otp_image, .standby_req, .turnoff_req, .psel, .penable, .pwrite,
		.paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr, .buck_a_ctrl,
		.buck_b_volt_code, .buck_a_off, .buck_a_step_en, .buck_b_step_en,
		.otp_loaded);
	apb_host_model host (.sys_clk, .psel, .penable, .pwrite, .paddr,
		.pwdata, .pstrb, .prdata, .pready);
	// ========================================
	// Helpers; register index i sits at byte 4*i
	function automatic logic [7:0] msk(int i);
		if (i < 4) return buck_regs_pkg::MASK_SCRATCH;
		if (i == 7) return buck_regs_pkg::MASK_MODE;
		if (i == 8) return buck_regs_pkg::MASK_CONF;
		return buck_regs_pkg::MASK_VOLT;
	endfunction : msk
	function automatic logic [7:0] dflt(int i);
		if (i < 4) return buck_regs_pkg::SCRATCH_RESET;
		return otp_image[95 - 8 * i -: 8] & msk(i);
	endfunction : dflt
	task automatic chk(input string nm, input logic [31:0] s,
		input logic [31:0] e);
		checked++;
		if (s !== e) begin
			miscompares++;
			$display("[FAIL] %s expected %h seen %h", nm, e, s);
		end
	endtask : chk
	task automatic wr(input int i, input logic [7:0] d,
		input logic [3:0] s = 4'hF);
		logic [31:0] q;
		host.xfer(1'h1, 8'(4 * i), {24'h0, d}, s, q);
	endtask : wr
	task automatic rd(input int i, input logic [7:0] e);
		logic [31:0] q;
		host.xfer(1'h0, 8'(4 * i), 32'h0, 4'h0, q);
		chk($sformatf("reg %h", 8'(4 * i)), q, {24'h0, e});
	endtask : rd
	task automatic wait_step(output int k);
		k = 0;
		do begin
			@(posedge sys_clk);
			k++;
		end while (buck_a_step_en !== 1'h1);
	endtask : wait_step
	task automatic print_verdict();
		$display("checked %0d miscompares %0d", checked, miscompares);
		if (miscompares == 0 && checked > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : print_verdict
	// Hang guard, well above the thousand or so cycles needed
	always @(posedge sys_clk) begin
		cyc <= cyc + 1;
		if (cyc == 8000) begin
			miscompares = miscompares + 1;
			print_verdict();
		end
	end
	// ========================================
	// Tests
	initial begin
		repeat (6) @(posedge sys_clk);
		rst_b <= 1'h1;
		coin_cell_por_n <= 1'h1;
		repeat (2) @(posedge sys_clk);
		for (int i = 0; i < 12; i++) rd(i, dflt(i));
		$display("test defaults done");
		// Bit 6 kept low here so the step rate is not toggled
		for (int i = 0; i < 13; i++) begin
			n = (i == 8) ? 8'hBF : 8'hFF;
			wr(i, 8'(n));
			rd(i, i < 12 ? 8'(n) & msk(i) : 8'h00);
			wr(i, 8'h00);
			rd(i, 8'h00);
		end
		wr(0, 8'h5A);
		wr(0, 8'hA5, 4'hE);
		rd(0, 8'h5A);
		$display("test access done");
		rst_b <= 1'h0;
		@(posedge sys_clk);
		rst_b <= 1'h1;
		repeat (2) @(posedge sys_clk);
		rd(0, 8'h5A);
		rd(4, dflt(4));
		coin_cell_por_n <= 1'h0;
		@(posedge sys_clk);
		coin_cell_por_n <= 1'h1;
		rd(0, 8'h00);
		$display("test resets done");
		for (int i = 4; i < 12; i++) wr(i, cfg[i]);
		for (int s = 0; s < 3; s++) begin
			standby_req <= (s == 1);
			turnoff_req <= (s == 2);
			repeat (4) @(posedge sys_clk);
			chk("buck a", 32'(buck_a_ctrl), {16'h0, cfg[4 + s][4:0], 11'h2DB});
			chk("buck b", 32'(buck_b_volt_code), 32'(cfg[9 + s][4:0]));
			chk("off", 32'(buck_a_off), 32'h0);
		end
		wr(7, 8'h05);
		repeat (3) @(posedge sys_clk);
		chk("off", 32'(buck_a_off), 32'h1);
		turnoff_req <= 1'h0;
		for (int r = 0; r < 2; r++) begin
			wr(8, 8'(r * 64));
			rd(8, 8'(r * 64));
			repeat (3) wait_step(n);
			chk("step period", n, 80 + r * 80);
			chk("step b", 32'(buck_b_step_en), 32'h1);
		end
		$display("test controls done");
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
